//--- rtl/hkadc_scheduler.v
`timescale 1ns/1ns
`include "hkadc_regs.vh"
// Overview of operation
// R01 - interval, delta, start registers at F9, F3, D8
// R02 - threshold and result registers at FA, EF, DF, D7
// R03 - software writes zero to interval bits 7:6
// R04 - bits 5:4 set supply interval 8/2/1 min
// R05 - bits 3:2 set battery interval 16/4/1 min
// R06 - bits 1:0 set temperature interval 8/2/1 min
// R07 - delta bits 5:3 set temperature change threshold
// R08 - delta bits 2:0 set supply change threshold
// R09 - background runs in battery and sleep modes
// R10 - compare temperature with last interrupting result
// R11 - start bits self clear on converter accept
// R12 - interrupt when battery below low threshold
// R13 - results update only with converter interrupt; the code also loads them on sfr writes
// R14 - intervals counted from always-on timebase
module hkadc_scheduler (
   // clock and reset
   input wire clk,
   input wire rst,
   // sfr access from the core
   input wire [7:0] sfr_addr,
   input wire sfr_wr,
   input wire sfr_rd,
   input wire [7:0] sfr_wdata,
   output reg [7:0] sfr_rdata,
   // always-on timebase, one second pulse from the rtc domain
   input wire rtc_sec_pulse,
   // power mode, informational only
   input wire battery_active_mode,
   input wire sleep_mode,
   // converter handshake
   output reg conv_req,
   output reg [1:0] conv_channel,
   input wire conv_ack,
   input wire conv_done,
   input wire [7:0] conv_result,
   // interrupt pulses toward the core
   output reg temp_irq,
   output reg batt_irq,
   output reg supply_irq,
   output reg batt_low_irq
);
   // =====================================
   // functions
   function [15:0] sup_period;
      input [1:0] code;
      case (code)
         2'b01: sup_period = `HKADC_MIN_8;
         2'b10: sup_period = `HKADC_MIN_2;
         2'b11: sup_period = `HKADC_MIN_1;
         default: sup_period = 16'h0000;
      endcase
   endfunction
   function [15:0] bat_period;
      input [1:0] code;
      case (code)
         2'b01: bat_period = `HKADC_MIN_16;
         2'b10: bat_period = `HKADC_MIN_4;
         2'b11: bat_period = `HKADC_MIN_1;
         default: bat_period = 16'h0000;
      endcase
   endfunction
   // change interrupt decision shared by temperature and supply
   function change_hit;
      input [2:0] thr;
      input [7:0] now;
      input [7:0] last;
      reg [7:0] diff;
      begin
         diff = (now > last) ? now - last : last - now;
         if (thr == 3'b000) begin
            change_hit = 1'b0;
         end else if (thr == 3'b111) begin
            change_hit = 1'b1;
         end else begin
            change_hit = diff > {5'b00000, thr};
         end
      end
   endfunction
   // =====================================
   // registers
   reg [7:0] interval_ctl;
   reg [7:0] change_thr;
   reg [7:0] meas_start;
   reg [7:0] batt_low_thr;
   reg [7:0] temp_result;
   reg [7:0] batt_result;
   reg [7:0] supply_result;
   reg [7:0] temp_last;
   reg [7:0] supply_last;
   reg [2:0] pend_bg;
   reg [2:0] pend_single;
   reg sec_s1, sec_s2, sec_s3;
   wire sec_tick = sec_s2 & ~sec_s3; // [R14]
   wire [2:0] due;
   localparam ST_IDLE = 3'b001;
   localparam ST_REQ = 3'b010;
   localparam ST_WAIT = 3'b100;
   reg [2:0] state;
   reg [1:0] cur_ch;
   reg cur_single;
   // =====================================
   // timebase crossing
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         sec_s1 <= 1'b0;
         sec_s2 <= 1'b0;
         sec_s3 <= 1'b0;
      end else begin
         sec_s1 <= rtc_sec_pulse;
         sec_s2 <= sec_s1;
         sec_s3 <= sec_s2;
      end
   end
   // =====================================
   // interval timers, running regardless of power mode
   // restart on a write to the interval register, so a new setting counts from the write
   wire wr_interval = sfr_wr && (sfr_addr == `HKADC_ADDR_INTERVAL);
   hkadc_interval_timer u_bat_timer (
      .clk(clk), .rst(rst), .sec_tick(sec_tick),
      .period(bat_period(interval_ctl[`HKADC_BAT_INT_HI:`HKADC_BAT_INT_LO])), // [R05]
      .clear(wr_interval), .due(due[`HKADC_GO_BATT])
   );
   hkadc_interval_timer u_tmp_timer (
      .clk(clk), .rst(rst), .sec_tick(sec_tick),
      .period(sup_period(interval_ctl[`HKADC_TMP_INT_HI:`HKADC_TMP_INT_LO])), // [R06] [R09]
      .clear(wr_interval), .due(due[`HKADC_GO_TEMP])
   );
   hkadc_interval_timer u_sup_timer (
      .clk(clk), .rst(rst), .sec_tick(sec_tick),
      .period(sup_period(interval_ctl[`HKADC_SUP_INT_HI:`HKADC_SUP_INT_LO])), // [R04]
      .clear(wr_interval), .due(due[`HKADC_GO_SUPPLY])
   );
   // =====================================
   // sfr write and read, register file
   wire wr_start = sfr_wr && (sfr_addr == `HKADC_ADDR_MEAS_START);
   wire accept = (state == ST_REQ) && conv_ack;
   wire [2:0] accept_bit = {cur_ch == `HKADC_CH_SUPPLY, cur_ch == `HKADC_CH_TEMP, cur_ch == `HKADC_CH_BATT};
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         interval_ctl <= `HKADC_RST_BYTE;
         change_thr <= `HKADC_RST_BYTE;
         meas_start <= `HKADC_RST_BYTE;
         batt_low_thr <= `HKADC_RST_BYTE;
         sfr_rdata <= `HKADC_RST_BYTE;
      end else begin
         if (sfr_wr) begin
            case (sfr_addr)
               `HKADC_ADDR_INTERVAL: interval_ctl <= sfr_wdata; // [R01] [R03]
               `HKADC_ADDR_CHANGE_THR: change_thr <= sfr_wdata; // [R01] [R07] [R08]
               `HKADC_ADDR_BATT_LOW_THR: batt_low_thr <= sfr_wdata; // [R02]
               default: ;
            endcase
         end
         // a write racing the accept wins: a bit set again asks for another conversion
         if (wr_start) begin
            meas_start <= sfr_wdata; // [R11]
         end else if (accept && cur_single) begin
            meas_start <= meas_start & ~{5'b00000, accept_bit}; // [R11]
         end
         if (sfr_rd) begin
            case (sfr_addr)
               `HKADC_ADDR_INTERVAL: sfr_rdata <= interval_ctl;
               `HKADC_ADDR_CHANGE_THR: sfr_rdata <= change_thr;
               `HKADC_ADDR_MEAS_START: sfr_rdata <= meas_start;
               `HKADC_ADDR_BATT_LOW_THR: sfr_rdata <= batt_low_thr;
               `HKADC_ADDR_SUPPLY_RESULT: sfr_rdata <= supply_result; // [R02]
               `HKADC_ADDR_BATT_RESULT: sfr_rdata <= batt_result;
               `HKADC_ADDR_TEMP_RESULT: sfr_rdata <= temp_result;
               default: sfr_rdata <= `HKADC_RST_BYTE;
            endcase
         end
      end
   end
   // =====================================
   // request arbiter and converter handshake
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         state <= ST_IDLE;
         pend_bg <= 3'b000;
         conv_req <= 1'b0;
         conv_channel <= `HKADC_CH_BATT;
         cur_ch <= `HKADC_CH_BATT;
         cur_single <= 1'b0;
      end else begin
         // new due wins over the clear on accept
         pend_bg <= (pend_bg & ~(accept_bit & {3{accept & ~cur_single}})) | due;
         case (state)
            ST_IDLE: begin
               if (meas_start[2:0] != 3'b000) begin
                  cur_single <= 1'b1;
                  cur_ch <= meas_start[`HKADC_GO_BATT] ? `HKADC_CH_BATT :
                            meas_start[`HKADC_GO_TEMP] ? `HKADC_CH_TEMP : `HKADC_CH_SUPPLY;
                  state <= ST_REQ;
               end else if (pend_bg != 3'b000) begin
                  cur_single <= 1'b0;
                  cur_ch <= pend_bg[`HKADC_GO_BATT] ? `HKADC_CH_BATT :
                            pend_bg[`HKADC_GO_TEMP] ? `HKADC_CH_TEMP : `HKADC_CH_SUPPLY;
                  state <= ST_REQ;
               end
            end
            ST_REQ: begin
               conv_req <= ~conv_ack;
               conv_channel <= cur_ch;
               if (conv_ack) begin
                  state <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               if (conv_done) begin
                  state <= ST_IDLE;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end
   // =====================================
   // results and interrupts
   wire done_now = (state == ST_WAIT) && conv_done;
   wire tmp_hit = cur_single | change_hit(change_thr[`HKADC_TMP_THR_HI:`HKADC_TMP_THR_LO], conv_result, temp_last);
   wire sup_hit = cur_single | change_hit(change_thr[`HKADC_SUP_THR_HI:`HKADC_SUP_THR_LO], conv_result, supply_last);
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         temp_result <= `HKADC_RST_BYTE;
         batt_result <= `HKADC_RST_BYTE;
         supply_result <= `HKADC_RST_BYTE;
         temp_last <= `HKADC_RST_BYTE;
         supply_last <= `HKADC_RST_BYTE;
         temp_irq <= 1'b0;
         batt_irq <= 1'b0;
         supply_irq <= 1'b0;
         batt_low_irq <= 1'b0;
      end else begin
         temp_irq <= 1'b0;
         batt_irq <= 1'b0;
         supply_irq <= 1'b0;
         batt_low_irq <= 1'b0;
         if (sfr_wr && sfr_addr == `HKADC_ADDR_TEMP_RESULT) temp_result <= sfr_wdata;
         if (sfr_wr && sfr_addr == `HKADC_ADDR_BATT_RESULT) batt_result <= sfr_wdata;
         if (sfr_wr && sfr_addr == `HKADC_ADDR_SUPPLY_RESULT) supply_result <= sfr_wdata;
         if (done_now) begin
            case (cur_ch)
               `HKADC_CH_TEMP: begin
                  if (tmp_hit) begin // [R10] [R07]
                     temp_result <= conv_result; // [R13]
                     temp_last <= conv_result;
                     temp_irq <= 1'b1;
                  end
               end
               `HKADC_CH_SUPPLY: begin
                  if (sup_hit) begin // [R08]
                     supply_result <= conv_result; // [R13]
                     supply_last <= conv_result;
                     supply_irq <= 1'b1;
                  end
               end
               default: begin
                  // battery reports on single request or when below threshold
                  if (cur_single || conv_result < batt_low_thr) begin
                     batt_result <= conv_result; // [R13]
                     batt_irq <= 1'b1;
                  end
                  batt_low_irq <= conv_result < batt_low_thr; // [R12]
               end
            endcase
         end
      end
   end
endmodule // hkadc_scheduler

//--- rtl/hkadc_regs.vh
`ifndef HKADC_REGS_VH
`define HKADC_REGS_VH
// =====================================
// sfr addresses
`define HKADC_ADDR_TEMP_RESULT 8'hd7
`define HKADC_ADDR_MEAS_START 8'hd8
`define HKADC_ADDR_BATT_RESULT 8'hdf
`define HKADC_ADDR_SUPPLY_RESULT 8'hef
`define HKADC_ADDR_CHANGE_THR 8'hf3
`define HKADC_ADDR_INTERVAL 8'hf9
`define HKADC_ADDR_BATT_LOW_THR 8'hfa
// =====================================
// field positions
`define HKADC_SUP_INT_HI 5
`define HKADC_SUP_INT_LO 4
`define HKADC_BAT_INT_HI 3
`define HKADC_BAT_INT_LO 2
`define HKADC_TMP_INT_HI 1
`define HKADC_TMP_INT_LO 0
`define HKADC_TMP_THR_HI 5
`define HKADC_TMP_THR_LO 3
`define HKADC_SUP_THR_HI 2
`define HKADC_SUP_THR_LO 0
`define HKADC_GO_SUPPLY 2
`define HKADC_GO_TEMP 1
`define HKADC_GO_BATT 0
// =====================================
// reset values
`define HKADC_RST_BYTE 8'h00
// =====================================
// timing, in timebase ticks of one second
`define HKADC_TICKS_PER_MIN 60
`define HKADC_MIN_1 16'd60
`define HKADC_MIN_2 16'd120
`define HKADC_MIN_4 16'd240
`define HKADC_MIN_8 16'd480
`define HKADC_MIN_16 16'd960
// channel codes toward the converter
`define HKADC_CH_BATT 2'd0
`define HKADC_CH_TEMP 2'd1
`define HKADC_CH_SUPPLY 2'd2
`endif

//--- rtl/hkadc_interval_timer.v
`timescale 1ns/1ns
// =====================================
// per-channel background interval timer
module hkadc_interval_timer (
   // clock and reset
   input wire clk,
   input wire rst,
   // timebase and setting
   input wire sec_tick,
   input wire [15:0] period,
   input wire clear,
   // request
   output reg due
);
   reg [15:0] count;
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         count <= 16'h0000;
         due <= 1'b0;
      end else begin
         due <= 1'b0;
         if (period == 16'h0000) begin
            count <= 16'h0000;
         end else if (sec_tick) begin
            if (count >= period - 16'h0001) begin
               count <= 16'h0000;
               due <= 1'b1;
            end else begin
               count <= count + 16'h0001;
            end
         end
         if (clear) begin
            count <= 16'h0000;
         end
      end
   end
endmodule // hkadc_interval_timer

//--- tb/hkadc_scheduler_properties.sv
`timescale 1ns/1ns
// ==========
// converter handshake and interrupt checks
module hkadc_props (
   // clock and reset
   input wire clk,
   input wire rst,
   // core side
   input wire [7:0] sfr_addr,
   input wire sfr_rd,
   input wire [7:0] sfr_rdata,
   // converter side
   input wire conv_req,
   input wire [1:0] conv_channel,
   input wire conv_ack,
   input wire conv_done,
   // interrupts
   input wire temp_irq,
   input wire batt_irq,
   input wire supply_irq,
   input wire batt_low_irq
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   req_drop_a: assert property (conv_req && conv_ack |=> !conv_req)
      else $error("request held after accept");
   req_hold_a: assert property (conv_req && !conv_ack |=> conv_req && $stable(conv_channel))
      else $error("request changed before accept");
   chan_legal_a: assert property (conv_req |-> conv_channel != 2'h3)
      else $error("unknown channel code");
   temp_cause_a: assert property (temp_irq |-> $past(conv_done))
      else $error("temperature irq without result");
   batt_cause_a: assert property (batt_irq |-> $past(conv_done))
      else $error("battery irq without result");
   supply_cause_a: assert property (supply_irq |-> $past(conv_done))
      else $error("supply irq without result");
   low_cause_a: assert property (batt_low_irq |-> $past(conv_done) && batt_irq)
      else $error("low battery irq without result");
   irq_pulse_a: assert property (temp_irq || supply_irq |=> !temp_irq && !supply_irq)
      else $error("irq longer than one cycle");
   unmapped_read_a: assert property (sfr_rd && sfr_addr == 8'h00 |=> sfr_rdata == 8'h00)
      else $error("unmapped read not zero");
   cover property (temp_irq);
   cover property (batt_low_irq);
   cover property (conv_req && conv_ack && conv_channel == 2'h2);
endmodule // hkadc_props

bind hkadc_scheduler hkadc_props u_props (.clk(clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_rd(sfr_rd),
   .sfr_rdata(sfr_rdata), .conv_req(conv_req), .conv_channel(conv_channel), .conv_ack(conv_ack),
   .conv_done(conv_done), .temp_irq(temp_irq), .batt_irq(batt_irq), .supply_irq(supply_irq),
   .batt_low_irq(batt_low_irq));

//--- tb/hkadc_conv_model.sv
`timescale 1ns/1ns
// ==========
// converter stand-in: accepts, then answers after a delay
module hkadc_conv_model (
   // clock and reset
   input wire clk,
   input wire rst,
   // handshake
   input wire conv_req,
   input wire [1:0] conv_channel,
   output reg conv_ack,
   output reg conv_done,
   output reg [7:0] conv_result,
   // test control
   input wire [31:0] values,
   input wire [3:0] delay
);
   reg busy;
   reg [3:0] cnt;
   reg [1:0] chan;
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         conv_ack <= 1'b0;
         conv_done <= 1'b0;
         conv_result <= 8'h00;
         busy <= 1'b0;
         cnt <= 4'h0;
         chan <= 2'h0;
      end else begin
         conv_ack <= conv_req & ~busy;
         conv_done <= busy && cnt == 4'h0;
         if (conv_req && !busy) begin
            busy <= 1'b1;
            cnt <= delay;
            chan <= conv_channel;
         end
         // result line toggles outside the done cycle so a late sample shows
         if (busy && cnt == 4'h0) begin
            busy <= 1'b0;
            conv_result <= values[chan*8 +: 8];
         end else begin
            conv_result <= ~conv_result;
            if (busy) cnt <= cnt - 4'h1;
         end
      end
   end
endmodule // hkadc_conv_model

//--- tb/hkadc_scheduler_bench.sv
`timescale 1ns/1ns
module hkadc_scheduler_bench;
   reg clk = 1'b0;
   reg rst = 1'b1;
   reg [7:0] sfr_addr = 8'h00;
   reg sfr_wr = 1'b0;
   reg sfr_rd = 1'b0;
   reg [7:0] sfr_wdata = 8'h00;
   reg rtc_sec_pulse = 1'b0;
   reg battery_active_mode = 1'b0;
   reg sleep_mode = 1'b0;
   reg tick_en = 1'b0;
   reg [1:0] tdiv = 2'h0;
   reg [31:0] values = 32'h00504010;
   reg [3:0] delay = 4'h8;
   wire [7:0] sfr_rdata, conv_result;
   wire [1:0] conv_channel;
   wire conv_req, conv_ack, conv_done, temp_irq, batt_irq, supply_irq, batt_low_irq;
   integer err_count = 0;
   integer compares = 0;
   integer n_t = 0, n_b = 0, n_s = 0, n_l = 0, i;
   localparam [63:0] all_addr = 64'hd7d8dfeff3f9fa00;
   localparam [31:0] rw_addr = 32'hf9f3faef;
   localparam [31:0] rw_data = 32'h3f2da55a;
   hkadc_scheduler dut (.clk(clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
      .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .rtc_sec_pulse(rtc_sec_pulse),
      .battery_active_mode(battery_active_mode), .sleep_mode(sleep_mode), .conv_req(conv_req),
      .conv_channel(conv_channel), .conv_ack(conv_ack), .conv_done(conv_done), .conv_result(conv_result),
      .temp_irq(temp_irq), .batt_irq(batt_irq), .supply_irq(supply_irq), .batt_low_irq(batt_low_irq));
   hkadc_conv_model conv (.clk(clk), .rst(rst), .conv_req(conv_req), .conv_channel(conv_channel),
      .conv_ack(conv_ack), .conv_done(conv_done), .conv_result(conv_result), .values(values), .delay(delay));
   initial begin
      forever #5 clk = ~clk;
   end
   // ==========
   // fast timebase, one tick each four cycles, and irq tally
   always @(posedge clk) begin
      tdiv <= tdiv + 2'h1;
      rtc_sec_pulse <= tick_en & tdiv[1];
      if (temp_irq === 1'b1) n_t <= n_t + 1;
      if (batt_irq === 1'b1) n_b <= n_b + 1;
      if (supply_irq === 1'b1) n_s <= n_s + 1;
      if (batt_low_irq === 1'b1) n_l <= n_l + 1;
   end
   task wr(input [7:0] a, input [7:0] d);
      begin
         @(posedge clk);
         sfr_addr <= a;
         sfr_wdata <= d;
         sfr_wr <= 1'b1;
         @(posedge clk);
         sfr_wr <= 1'b0;
      end
   endtask
   task chk(input [8*12:1] name, input [7:0] seen, input [7:0] exp);
      begin
         compares = compares + 1;
         if (seen !== exp) begin
            err_count = err_count + 1;
            $display("unexpected %0s: expected %h, seen %h", name, exp, seen);
         end
      end
   endtask
   task rchk(input [7:0] a, input [7:0] exp);
      begin
         @(posedge clk);
         sfr_addr <= a;
         sfr_rd <= 1'b1;
         @(posedge clk);
         sfr_rd <= 1'b0;
         // data loaded on the strobe edge, taken one edge later while it still stands
         @(posedge clk);
         chk("sfr read", sfr_rdata, exp);
      end
   endtask
   task irqs(input [7:0] t, input [7:0] b, input [7:0] s, input [7:0] l);
      begin
         chk("temp irqs", n_t[7:0], t);
         chk("batt irqs", n_b[7:0], b);
         chk("supply irqs", n_s[7:0], s);
         chk("low irqs", n_l[7:0], l);
      end
   endtask
   task print_verdict;
      begin
         $display("compares %0d, mismatches %0d", compares, err_count);
         if (err_count == 0 && compares > 0) $display("No errors found");
         else $display("Errors were found");
         $finish;
      end
   endtask
   initial begin
      #100000;
      err_count = err_count + 1;
      print_verdict;
   end
   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      for (i = 0; i < 8; i = i + 1) rchk(all_addr[i*8 +: 8], 8'h00);
      $display("test reset values done");
      for (i = 0; i < 4; i = i + 1) begin
         wr(rw_addr[i*8 +: 8], rw_data[i*8 +: 8]);
         rchk(rw_addr[i*8 +: 8], rw_data[i*8 +: 8]);
      end
      wr(8'hf9, 8'h00);
      $display("test read write done");
      // all three single requests at once, served one after another
      wr(8'hfa, 8'h80);
      wr(8'hf3, 8'h17);
      wr(8'hd8, 8'h07);
      for (i = 0; i < 400 && n_s < 1; i = i + 1) @(posedge clk);
      rchk(8'hd8, 8'h00);
      rchk(8'hd7, 8'h40);
      rchk(8'hdf, 8'h10);
      rchk(8'hef, 8'h50);
      irqs(8'd1, 8'd1, 8'd1, 8'd1);
      $display("test single conversions done");
      // background in sleep: temp moves by 2, not above threshold 2
      delay <= 4'h1;
      sleep_mode <= 1'b1;
      values <= 32'h00554210;
      wr(8'hf9, 8'h3f);
      tick_en <= 1'b1;
      repeat (360) @(posedge clk);
      irqs(8'd1, 8'd2, 8'd2, 8'd2);
      rchk(8'hd7, 8'h40);
      rchk(8'hef, 8'h55);
      $display("test background sleep done");
      // battery mode: temp drops by 3 from the last interrupting value
      sleep_mode <= 1'b0;
      battery_active_mode <= 1'b1;
      values <= 32'h00553d10;
      repeat (240) @(posedge clk);
      irqs(8'd2, 8'd3, 8'd3, 8'd3);
      rchk(8'hd7, 8'h3d);
      $display("test background battery mode done");
      // slower codes: supply and temp every 2 min, battery every 4 min; temp change irq off
      wr(8'hf3, 8'h07);
      values <= 32'h00552010;
      wr(8'hf9, 8'h2a);
      repeat (600) @(posedge clk);
      irqs(8'd2, 8'd3, 8'd4, 8'd3);
      rchk(8'hd7, 8'h3d);
      rchk(8'hef, 8'h55);
      $display("test slow intervals done");
      print_verdict;
   end
endmodule // hkadc_scheduler_bench
